// *** lcef_defs.svh ***
// offsets, field positions, reset values and codes of the load control event frame
`ifndef LCEF_DEFS_SVH
`define LCEF_DEFS_SVH
// frame layout
`define LCEF_START_DELIM 8'h7E
`define LCEF_API_TYPE 8'h11
`define LCEF_BODY_LEN 16'h002E
`define LCEF_OFF_TYPE 16'h0003
`define LCEF_OFF_FCTL 16'h0017
`define LCEF_OFF_LAST 16'h0030
`define LCEF_OFF_CSUM 16'h0031
`define LCEF_CSUM_GOOD 8'hFF
`define LCEF_CMD_EVENT 8'h00
// payload slots, counted from the frame control byte
`define LCEF_SLOTS 26
`define LCEF_SL_FCTL 0
`define LCEF_SL_SEQ 1
`define LCEF_SL_CMD 2
`define LCEF_SL_EVT 3
`define LCEF_SL_CLASS 7
`define LCEF_SL_GROUP 9
`define LCEF_SL_START 10
`define LCEF_SL_DUR 14
`define LCEF_SL_CRIT 16
`define LCEF_SL_COOLOFF 17
`define LCEF_SL_HEATOFF 18
`define LCEF_SL_COOLSP 19
`define LCEF_SL_HEATSP 21
`define LCEF_SL_AVG 23
`define LCEF_SL_DUTY 24
`define LCEF_SL_DCTL 25
// frame control bits
`define LCEF_FC_TYPE_LSB 0
`define LCEF_FC_TYPE_CLUSTER 2'b01
`define LCEF_FC_MFG 2
`define LCEF_FC_DIR 3
`define LCEF_FC_NODFLT 4
// not-used codes
`define LCEF_SP_UNUSED 16'h8000
`define LCEF_AVG_UNUSED 8'h80
`define LCEF_DUTY_UNUSED 8'hFF
`define LCEF_OFFS_UNUSED 8'hFF
// register word indices
`define LCEF_RI_CTRL 3'h0
`define LCEF_RI_EVT 3'h1
`define LCEF_RI_START 3'h2
`define LCEF_RI_CLDUR 3'h3
`define LCEF_RI_MISC 3'h4
`define LCEF_RI_SETPT 3'h5
`define LCEF_RI_LIMIT 3'h6
`define LCEF_RI_STAT 3'h7
`define LCEF_CTRL_GO 0
`define LCEF_CTRL_DIR 1
`define LCEF_CTRL_BUSY 2
// register reset values
`define LCEF_RST_ZERO 32'h0000_0000
`define LCEF_RST_MISC 32'hFFFF_0000
`define LCEF_RST_SETPT 32'h8000_8000
`define LCEF_RST_LIMIT 32'h0100_FF80
`endif

// *** lcef_pkg.sv ***
// types of the parser end of the load control event frame, also used by the bench
package lcef_pkg;
   typedef enum logic [2:0] {
      LCEF_HUNT,
      LCEF_LEN_HI,
      LCEF_LEN_LO,
      LCEF_BODY,
      LCEF_CSUM
   } lcef_rx_st_t;

   typedef struct packed {
      logic [31:0] event_id;
      logic [15:0] dev_class;
      logic [7:0] group;
      logic [31:0] start_time;
      logic [15:0] duration;
      logic [7:0] crit;
      logic [7:0] cool_off;
      logic [7:0] heat_off;
      logic [15:0] cool_sp;
      logic [15:0] heat_sp;
      logic [7:0] avg_load;
      logic [7:0] duty;
      logic [7:0] duty_ctl;
      logic [7:0] seq;
      logic dir_srv_cli;
      logic no_dflt_rsp;
   } lcef_evt_t;
endpackage : lcef_pkg

// *** lcef_link_if.sv ***
// byte stream link between frame composer and frame parser
`timescale 1ns/100ps
`default_nettype none
interface lcef_link_if;
   logic [7:0] byte_data;
   logic byte_valid;
   logic byte_ready;

   modport host (
      output byte_data,
      output byte_valid,
      input byte_ready
   );

   modport dev (
      input byte_data,
      input byte_valid,
      output byte_ready
   );
endinterface : lcef_link_if
`default_nettype wire

// *** lcef_dev.sv ***
// frame parser end: checks the frame and unpacks the load control event
`timescale 1ns/100ps
`default_nettype none
`include "lcef_defs.svh"
module lcef_dev (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // link
   lcef_link_if.dev link,
   // event out
   output lcef_pkg::lcef_evt_t evt,
   output logic evt_stb,
   output logic cool_sp_used,
   output logic heat_sp_used,
   output logic avg_used,
   output logic duty_used,
   // errors
   output logic err_csum,
   output logic err_fmt
);
   lcef_pkg::lcef_rx_st_t st_ff;
   logic [15:0] pos_ff;
   logic [15:0] len_ff;
   logic [7:0] sum_ff;
   logic [7:0] ftype_ff;
   logic [7:0] fr_ff [0:`LCEF_SLOTS-1];
   lcef_pkg::lcef_evt_t evt_ff;
   logic evt_stb_ff, err_csum_ff, err_fmt_ff;
   logic [3:0] used_ff;

   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      le16 = {hi, lo};
   endfunction : le16

   function automatic logic [31:0] le32(input int s);
      le32 = {fr_ff[s+3], fr_ff[s+2], fr_ff[s+1], fr_ff[s]};
   endfunction : le32

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire take = link.byte_valid;
   wire [7:0] b = link.byte_data;
   wire [7:0] fctl = fr_ff[`LCEF_SL_FCTL];
   wire csum_ok = (8'(sum_ff + b) == `LCEF_CSUM_GOOD);
   wire in_slots = (pos_ff >= `LCEF_OFF_FCTL) && (pos_ff <= `LCEF_OFF_LAST);
   wire [4:0] slot = 5'(pos_ff - `LCEF_OFF_FCTL);
   wire fmt_ok = (len_ff == `LCEF_BODY_LEN) && (ftype_ff == `LCEF_API_TYPE)
      && (fctl[`LCEF_FC_TYPE_LSB +: 2] == `LCEF_FC_TYPE_CLUSTER)
      && !fctl[`LCEF_FC_MFG]
      && (fr_ff[`LCEF_SL_CMD] == `LCEF_CMD_EVENT);
   wire [15:0] cool_sp = le16(fr_ff[`LCEF_SL_COOLSP], fr_ff[`LCEF_SL_COOLSP+1]);
   wire [15:0] heat_sp = le16(fr_ff[`LCEF_SL_HEATSP], fr_ff[`LCEF_SL_HEATSP+1]);
   lcef_pkg::lcef_evt_t nxt_evt;
   always_comb begin
      nxt_evt.event_id = le32(`LCEF_SL_EVT);
      nxt_evt.dev_class = le16(fr_ff[`LCEF_SL_CLASS], fr_ff[`LCEF_SL_CLASS+1]);
      nxt_evt.group = fr_ff[`LCEF_SL_GROUP];
      nxt_evt.start_time = le32(`LCEF_SL_START);
      nxt_evt.duration = le16(fr_ff[`LCEF_SL_DUR], fr_ff[`LCEF_SL_DUR+1]);
      nxt_evt.crit = fr_ff[`LCEF_SL_CRIT];
      nxt_evt.cool_off = fr_ff[`LCEF_SL_COOLOFF];
      nxt_evt.heat_off = fr_ff[`LCEF_SL_HEATOFF];
      nxt_evt.cool_sp = cool_sp;
      nxt_evt.heat_sp = heat_sp;
      nxt_evt.avg_load = fr_ff[`LCEF_SL_AVG];
      nxt_evt.duty = fr_ff[`LCEF_SL_DUTY];
      nxt_evt.duty_ctl = fr_ff[`LCEF_SL_DCTL];
      nxt_evt.seq = fr_ff[`LCEF_SL_SEQ];
      nxt_evt.dir_srv_cli = fctl[`LCEF_FC_DIR];
      nxt_evt.no_dflt_rsp = fctl[`LCEF_FC_NODFLT];
   end
   wire [3:0] nxt_used = {fr_ff[`LCEF_SL_DUTY] != `LCEF_DUTY_UNUSED,
      fr_ff[`LCEF_SL_AVG] != `LCEF_AVG_UNUSED,
      heat_sp != `LCEF_SP_UNUSED, cool_sp != `LCEF_SP_UNUSED};

   ////////////////////////////////////////////////////////////////////////////////
   // receive state machine
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= lcef_pkg::LCEF_HUNT;
         pos_ff <= 16'h0000;
         len_ff <= 16'h0000;
         sum_ff <= 8'h00;
         ftype_ff <= 8'h00;
      end else if (take) begin
         pos_ff <= pos_ff + 16'h0001;
         unique case (st_ff)
            lcef_pkg::LCEF_HUNT: begin
               pos_ff <= 16'h0001;
               if (b == `LCEF_START_DELIM) st_ff <= lcef_pkg::LCEF_LEN_HI;
            end
            lcef_pkg::LCEF_LEN_HI: begin
               len_ff[15:8] <= b;
               st_ff <= lcef_pkg::LCEF_LEN_LO;
            end
            lcef_pkg::LCEF_LEN_LO: begin
               len_ff[7:0] <= b;
               sum_ff <= 8'h00;
               st_ff <= ({len_ff[15:8], b} == 16'h0000) ? lcef_pkg::LCEF_CSUM
                  : lcef_pkg::LCEF_BODY;
            end
            lcef_pkg::LCEF_BODY: begin
               sum_ff <= 8'(sum_ff + b);
               if (pos_ff == `LCEF_OFF_TYPE) ftype_ff <= b;
               if (pos_ff == 16'(len_ff + 16'h0002)) st_ff <= lcef_pkg::LCEF_CSUM;
            end
            lcef_pkg::LCEF_CSUM: st_ff <= lcef_pkg::LCEF_HUNT;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (take && st_ff == lcef_pkg::LCEF_BODY && in_slots) fr_ff[slot] <= b;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // results
   wire at_csum = take && (st_ff == lcef_pkg::LCEF_CSUM);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         evt_ff <= '0;
         used_ff <= 4'h0;
         evt_stb_ff <= 1'b0;
         err_csum_ff <= 1'b0;
         err_fmt_ff <= 1'b0;
      end else begin
         evt_stb_ff <= at_csum && csum_ok && fmt_ok;
         err_csum_ff <= at_csum && !csum_ok;
         err_fmt_ff <= at_csum && csum_ok && !fmt_ok;
         if (at_csum && csum_ok && fmt_ok) begin
            evt_ff <= nxt_evt;
            used_ff <= nxt_used;
         end
      end
   end

   assign link.byte_ready = 1'b1;
   assign evt = evt_ff;
   assign evt_stb = evt_stb_ff;
   assign cool_sp_used = used_ff[0];
   assign heat_sp_used = used_ff[1];
   assign avg_used = used_ff[2];
   assign duty_used = used_ff[3];
   assign err_csum = err_csum_ff;
   assign err_fmt = err_fmt_ff;
endmodule : lcef_dev
`default_nettype wire

// *** lcef_host.sv ***
// frame composer end: APB registers in, load control event frame out as bytes
//
// How it works
// - heating set point at offsets 44-45
// - set point 0x8000 means not used
// - set points sent low byte first
// - load adjustment at 46, 0x80 unused
// - duty cycle at 47, 0xFF unused
// - offset 48 is event option bitmap
// - frame control byte at offset 23
// - frame type bits 01, cluster specific
// - manufacturer bit clear, no code bytes
// - direction bit 3 set: server to client; the composer sends CTRL bit 1 there, 0 after reset
// - default response on, reserved bits zero
// - cooling set point at offsets 42-43
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lcef_defs.svh"
module lcef_host #(
   parameter logic [63:0] DEST64 = 64'h0000_0000_0000_0000,
   parameter logic [15:0] NET16 = 16'hFFFE,
   parameter logic [7:0] SRC_EP = 8'h01,
   parameter logic [7:0] DST_EP = 8'h01,
   parameter logic [15:0] CLUSTER = 16'h0701,
   parameter logic [15:0] PROFILE = 16'h0109,
   parameter logic [7:0] FRAME_ID = 8'h01
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   lcef_link_if.host link
);
   logic [31:0] reg_ff [0:6];
   logic [31:0] prdata_ff;
   logic busy_ff;
   logic [5:0] idx_ff;
   logic [7:0] sum_ff;
   logic [7:0] data_ff;
   logic [7:0] sent_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // register decode
   wire [2:0] ri = paddr[4:2];
   wire mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   wire ro_hit = (ri == `LCEF_RI_STAT);
   wire acc = psel && penable;
   wire bad_wr = pwrite && (ro_hit || busy_ff);
   wire wr_ok = acc && mapped && !bad_wr;
   wire go = wr_ok && pwrite && (ri == `LCEF_RI_CTRL) && pwdata[`LCEF_CTRL_GO];
   wire [31:0] stat_word = {16'h0000, sent_ff, 7'h00, busy_ff};
   wire [31:0] ctrl_word = {29'h0, busy_ff, reg_ff[`LCEF_RI_CTRL][`LCEF_CTRL_DIR], 1'b0};
   wire [31:0] rd_word = !mapped ? 32'h0000_0000
      : (ri == `LCEF_RI_STAT) ? stat_word
      : (ri == `LCEF_RI_CTRL) ? ctrl_word
      : reg_ff[ri];

   ////////////////////////////////////////////////////////////////////////////////
   // register fields
   wire [31:0] evt_id = reg_ff[`LCEF_RI_EVT];
   wire [31:0] start_t = reg_ff[`LCEF_RI_START];
   wire [31:0] cldur = reg_ff[`LCEF_RI_CLDUR];
   wire [31:0] misc = reg_ff[`LCEF_RI_MISC];
   wire [31:0] setpt = reg_ff[`LCEF_RI_SETPT];
   wire [31:0] limit = reg_ff[`LCEF_RI_LIMIT];
   wire dir_bit = reg_ff[`LCEF_RI_CTRL][`LCEF_CTRL_DIR];
   wire [7:0] fctl = {3'b000,
      1'b0,
      dir_bit,
      1'b0,
      `LCEF_FC_TYPE_CLUSTER};

   ////////////////////////////////////////////////////////////////////////////////
   // frame byte selection
   function automatic logic [7:0] be_pick(input logic [63:0] v, input int n, input int k);
      be_pick = v[8*(n-1-k) +: 8];
   endfunction : be_pick

   function automatic logic [7:0] le_pick(input logic [31:0] v, input int k);
      le_pick = v[8*k +: 8];
   endfunction : le_pick

   function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [7:0] s);
      int k;
      k = int'(i);
      frame_byte = 8'h00;
      if (k == 0) frame_byte = `LCEF_START_DELIM;
      else if (k <= 2) frame_byte = be_pick({48'h0, `LCEF_BODY_LEN}, 2, k - 1);
      else if (k == 3) frame_byte = `LCEF_API_TYPE;
      else if (k == 4) frame_byte = FRAME_ID;
      else if (k <= 12) frame_byte = be_pick(DEST64, 8, k - 5);
      else if (k <= 14) frame_byte = be_pick({48'h0, NET16}, 2, k - 13);
      else if (k == 15) frame_byte = SRC_EP;
      else if (k == 16) frame_byte = DST_EP;
      else if (k <= 18) frame_byte = be_pick({48'h0, CLUSTER}, 2, k - 17);
      else if (k <= 20) frame_byte = be_pick({48'h0, PROFILE}, 2, k - 19);
      else if (k <= 22) frame_byte = 8'h00;
      else if (k == 23) frame_byte = fctl;
      else if (k == 24) frame_byte = limit[31:24];
      else if (k == 25) frame_byte = `LCEF_CMD_EVENT;
      else if (k <= 29) frame_byte = le_pick(evt_id, k - 26);
      else if (k <= 31) frame_byte = le_pick(cldur, k - 30);
      else if (k == 32) frame_byte = misc[7:0];
      else if (k <= 36) frame_byte = le_pick(start_t, k - 33);
      else if (k <= 38) frame_byte = le_pick(cldur, k - 35);
      else if (k <= 41) frame_byte = le_pick(misc, k - 38);
      else if (k <= 43) frame_byte = le_pick(setpt, k - 42);
      else if (k <= 45) frame_byte = le_pick(setpt, k - 42);
      else if (k <= 48) frame_byte = le_pick(limit, k - 46);
      else frame_byte = 8'(`LCEF_CSUM_GOOD - s);
   endfunction : frame_byte

   ////////////////////////////////////////////////////////////////////////////////
   // transmit sequencer
   wire fire = busy_ff && link.byte_ready;
   wire last = ({10'h000, idx_ff} == `LCEF_OFF_CSUM);
   wire in_sum = ({10'h000, idx_ff} >= `LCEF_OFF_TYPE) && ({10'h000, idx_ff} <= `LCEF_OFF_LAST);
   wire [7:0] nxt_sum = in_sum ? 8'(sum_ff + data_ff) : sum_ff;
   wire [5:0] nxt_idx = 6'(idx_ff + 6'h01);
   wire [7:0] nxt_data = frame_byte(nxt_idx, nxt_sum);
   wire [7:0] first_data = frame_byte(6'h00, 8'h00);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         idx_ff <= 6'h00;
         sum_ff <= 8'h00;
         data_ff <= 8'h00;
         sent_ff <= 8'h00;
      end else if (go) begin
         busy_ff <= 1'b1;
         idx_ff <= 6'h00;
         sum_ff <= 8'h00;
         data_ff <= first_data;
      end else if (fire) begin
         idx_ff <= nxt_idx;
         sum_ff <= nxt_sum;
         data_ff <= nxt_data;
         if (last) begin
            busy_ff <= 1'b0;
            sent_ff <= 8'(sent_ff + 8'h01);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register storage and read data
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_ff[`LCEF_RI_CTRL] <= `LCEF_RST_ZERO;
         reg_ff[`LCEF_RI_EVT] <= `LCEF_RST_ZERO;
         reg_ff[`LCEF_RI_START] <= `LCEF_RST_ZERO;
         reg_ff[`LCEF_RI_CLDUR] <= `LCEF_RST_ZERO;
         reg_ff[`LCEF_RI_MISC] <= `LCEF_RST_MISC;
         reg_ff[`LCEF_RI_SETPT] <= `LCEF_RST_SETPT;
         reg_ff[`LCEF_RI_LIMIT] <= `LCEF_RST_LIMIT;
      end else if (wr_ok && pwrite) begin
         reg_ff[ri] <= pwdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) prdata_ff <= 32'h0000_0000;
      else if (psel && !penable) prdata_ff <= rd_word;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = acc && (!mapped || bad_wr);
   assign link.byte_data = data_ff;
   assign link.byte_valid = busy_ff;
endmodule : lcef_host
`default_nettype wire

// *** lcef_chk.sv ***
// link assertions for the load control event frame
`timescale 1ns/100ps
`default_nettype none
module lcef_chk #(
   parameter logic [15:0] CLUSTER = 16'h0701
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // link
   input wire logic [7:0] byte_data,
   input wire logic byte_valid,
   input wire logic byte_ready
);
   logic [5:0] cnt_ff;
   logic [7:0] sum_ff;
   logic tk;
   logic [5:0] nxt_cnt;
   logic [7:0] nxt_sum;
   assign tk = byte_valid & byte_ready;
   assign nxt_cnt = !tk ? cnt_ff : (cnt_ff == 6'd49) ? 6'd0 : cnt_ff + 6'd1;
   assign nxt_sum = (!tk || cnt_ff > 6'd48) ? sum_ff :
      (cnt_ff < 6'd3) ? 8'h00 : sum_ff + byte_data;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 6'd0;
         sum_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
         sum_ff <= nxt_sum;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   a_delim_first: assert property (tk && cnt_ff == 6'd0 |-> byte_data == 8'h7E)
      else $error("bad start byte");
   a_len_msb_first: assert property (tk && cnt_ff == 6'd1 |->
      byte_data == 8'h00 ##1 byte_data == 8'h2E)
      else $error("bad length");
   a_hdr_msb_first: assert property (tk && cnt_ff == 6'd17 |->
      byte_data == CLUSTER[15:8] ##1 byte_data == CLUSTER[7:0])
      else $error("bad cluster order");
   a_fctl_type: assert property (tk && cnt_ff == 6'd23 |-> byte_data[1:0] == 2'b01)
      else $error("bad frame type");
   a_fctl_no_mfg: assert property (tk && cnt_ff == 6'd23 |-> !byte_data[2])
      else $error("manufacturer bit set");
   a_fctl_rsvd: assert property (tk && cnt_ff == 6'd23 |-> byte_data[7:4] == 4'h0)
      else $error("reserved bits set");
   a_cmd_event: assert property (tk && cnt_ff == 6'd25 |-> byte_data == 8'h00)
      else $error("bad command");
   a_csum_good: assert property (tk && cnt_ff == 6'd49 |->
      8'(sum_ff + byte_data) == 8'hFF)
      else $error("bad checksum");
   a_no_gap: assert property (byte_valid && !(tk && cnt_ff == 6'd49) |=> byte_valid)
      else $error("gap in frame");
   a_frame_end: assert property (tk && cnt_ff == 6'd49 |=> !byte_valid)
      else $error("frame too long");
   c_frame: cover property (tk && cnt_ff == 6'd49);
   c_dir: cover property (tk && cnt_ff == 6'd23 && byte_data[3]);
   c_avg_unused: cover property (tk && cnt_ff == 6'd46 && byte_data == 8'h80);
endmodule : lcef_chk
`default_nettype wire

// *** load_control_event_frame_tb.sv ***
// bench: composer to parser, plus a faulty sender on a second link
`timescale 1ns/100ps
`default_nettype none
module load_control_event_frame_tb;
   localparam logic [63:0] D64 = 64'h0123_4567_89AB_CDEF;
   localparam logic [15:0] CLU = 16'h0701;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] res;
   logic [3:0] used, used2;
   logic evt_stb, evt_stb2, err_csum, err_csum2, err_fmt, err_fmt2;
   lcef_pkg::lcef_evt_t evt, evt2;
   int err_total, comparisons, seed;
   logic [31:0] rg [8];
   logic [7:0] f [50];
   logic [7:0] got [$];
   lcef_link_if lk();
   lcef_link_if lk2();
   lcef_host #(.DEST64(D64), .NET16(16'h5678), .SRC_EP(8'h41), .DST_EP(8'h42),
      .CLUSTER(CLU), .PROFILE(16'h0109), .FRAME_ID(8'h01)) u_lcef_host (.clk_sys(clk_sys),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk.host));
   lcef_dev u_lcef_dev (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk.dev), .evt(evt),
      .evt_stb(evt_stb), .cool_sp_used(used[3]), .heat_sp_used(used[2]), .avg_used(used[1]),
      .duty_used(used[0]), .err_csum(err_csum), .err_fmt(err_fmt));
   lcef_dev u_lcef_dev2 (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk2.dev), .evt(evt2),
      .evt_stb(evt_stb2), .cool_sp_used(used2[3]), .heat_sp_used(used2[2]),
      .avg_used(used2[1]), .duty_used(used2[0]), .err_csum(err_csum2), .err_fmt(err_fmt2));
   lcef_chk #(.CLUSTER(CLU)) u_lcef_chk (.clk_sys(clk_sys), .rst_b(rst_b),
      .byte_data(lk.byte_data), .byte_valid(lk.byte_valid), .byte_ready(lk.byte_ready));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (lk.byte_valid === 1'b1 && lk.byte_ready === 1'b1)
      got.push_back(lk.byte_data);
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            return;
         end
      end
      check("pready wait", 1'b0, 1'b1);
      end_of_test();
   endtask : apb
   task automatic wait_res(input bit two);
      for (int n = 0; n < 300; n++) begin
         @(posedge clk_sys);
         res = two ? {evt_stb2, err_csum2, err_fmt2} : {evt_stb, err_csum, err_fmt};
         if (res !== 3'b000) return;
      end
      check("result wait", 1'b0, 1'b1);
      end_of_test();
   endtask : wait_res
   task automatic send2(input int junk);
      for (int i = -junk; i < 50; i++) begin
         lk2.byte_data <= (i < 0) ? 8'h55 : f[i];
         lk2.byte_valid <= 1'b1;
         @(posedge clk_sys);
         for (int n = 0; lk2.byte_ready !== 1'b1 && n < 50; n++) @(posedge clk_sys);
      end
      lk2.byte_valid <= 1'b0;
      lk2.byte_data <= ~f[49];
   endtask : send2
   function automatic void csum();
      logic [7:0] s;
      s = 8'h00;
      for (int i = 3; i < 49; i++) s += f[i];
      f[49] = 8'hFF - s;
   endfunction : csum
   function automatic void build();
      {f[0], f[1], f[2], f[3], f[4]} = 40'h7E_002E_1101;
      for (int i = 0; i < 8; i++) f[5 + i] = D64[63 - 8 * i -: 8];
      {f[13], f[14], f[15], f[16], f[17], f[18], f[19], f[20]} = {32'h5678_4142, CLU,
         16'h0109};
      {f[21], f[22], f[24], f[25]} = {16'h0000, rg[6][31:24], 8'h00};
      f[23] = {4'h0, rg[0][1], 3'b001};
      for (int i = 0; i < 4; i++) {f[26 + i], f[33 + i]} = {rg[1][8 * i +: 8], rg[2][8 * i +: 8]};
      {f[38], f[37], f[31], f[30]} = rg[3];
      {f[41], f[40], f[39], f[32]} = rg[4];
      {f[45], f[44], f[43], f[42]} = rg[5];
      {f[48], f[47], f[46]} = rg[6][23:0];
      csum();
   endfunction : build
   function automatic lcef_pkg::lcef_evt_t exp_evt();
      return '{rg[1], rg[3][15:0], rg[4][7:0], rg[2], rg[3][31:16], rg[4][15:8], rg[4][23:16],
         rg[4][31:24], rg[5][15:0], rg[5][31:16], rg[6][7:0], rg[6][15:8], rg[6][23:16],
         rg[6][31:24], rg[0][1], 1'b0};
   endfunction : exp_evt
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h0000_a3d0;
      {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
      {lk2.byte_valid, lk2.byte_data} = '0;
      rg = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_0000, 32'h8000_8000, 32'h0100_FF80, 32'h0};
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check("reset value", rd, rg[i]);
      end
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped read", {err, rd}, 33'h1_0000_0000);
      apb(1'b1, 8'h1C, 32'h0000_0001);
      check("status write", err, 1'b1);
      $display("test registers done");
      for (int k = 1; k <= 6; k++) begin
         for (int i = 1; i < 7; i++) rg[i] = $random(seed);
         if (k < 4) rg[5] = (k == 1) ? 32'h8000_8000 : (k == 2) ? 32'h7FFF_8001 : 32'h8000_0000;
         if (k < 4) rg[6][15:0] = (k == 1) ? 16'hFF80 : (k == 2) ? 16'hFE81 : 16'h0080;
         for (int i = 1; i < 7; i++) apb(1'b1, 8'(4 * i), rg[i]);
         rg[0] = {30'h0, k[0], 1'b1};
         got.delete();
         apb(1'b1, 8'h00, rg[0]);
         apb(1'b0, 8'h00, 32'h0);
         check("busy", rd[2:1], {1'b1, rg[0][1]});
         apb(1'b1, 8'h04, ~rg[1]);
         check("busy write", err, 1'b1);
         wait_res(1'b0);
         build();
         check("result", res, 3'b100);
         check("event", evt, exp_evt());
         check("used", used, {rg[5][15:0] != 16'h8000, rg[5][31:16] != 16'h8000,
            rg[6][7:0] != 8'h80, rg[6][15:8] != 8'hFF});
         for (int i = 0; i < 50; i++) check("frame byte", got[i], f[i]);
         apb(1'b0, 8'h1C, 32'h0);
         check("status", {rd[15:8], rd[0]}, {8'(k), 1'b0});
      end
      $display("test frames done");
      send2(3);
      wait_res(1'b1);
      check("hunt", res, 3'b100);
      for (int j = 0; j < 5; j++) begin
         build();
         f[(j == 4) ? 49 : (j < 2) ? 23 : (j == 2) ? 25 : 3] ^= (j == 0) ? 8'h04 : 8'h01;
         if (j < 4) csum();
         send2(0);
         wait_res(1'b1);
         check("fault", res, (j < 4) ? 3'b001 : 3'b010);
      end
      check("event kept", evt2, exp_evt());
      $display("test faults done");
      end_of_test();
   end
endmodule : load_control_event_frame_tb
`default_nettype wire
